// >>> core/iso_pkg.sv
package iso_pkg;
   // operation codes presented on the command port
   typedef enum logic [2:0] {
      ISO_OP_NONE = 3'b000,
      ISO_OP_INC = 3'b001,
      ISO_OP_IOR = 3'b010,
      ISO_OP_LSL = 3'b011,
      ISO_OP_LSR = 3'b100,
      ISO_OP_MOV = 3'b101
   } iso_op_t;

   localparam int ISO_ADDR_W = 7;
   localparam int ISO_DATA_W = 8;
   localparam int ISO_DEPTH = 128;
   localparam logic ISO_DEST_ACC = 1'b0;
   localparam logic ISO_DEST_REG = 1'b1;
   localparam logic [7:0] ISO_ACC_RST = 8'h00;
   localparam logic [7:0] ISO_FILE_RST = 8'h00;
   localparam logic [7:0] ISO_ONE = 8'h01;
   localparam logic [7:0] ISO_ZERO = 8'h00;
   localparam int ISO_MSB = 7;
   localparam int ISO_LSB = 0;
endpackage

// >>> core/iso_alu_if.sv
`timescale 1ns/100ps
// operand and result bundle between the core and its alu
interface iso_alu_if;
   iso_pkg::iso_op_t op;
   logic [7:0] acc;
   logic [7:0] src;
   logic carry_in;
   logic [7:0] result;
   logic carry_out;
   logic zero_out;
   logic carry_we;
   logic zero_we;
   modport core (output op, acc, src, carry_in,
      input result, carry_out, zero_out, carry_we, zero_we);
   modport alu (input op, acc, src, carry_in,
      output result, carry_out, zero_out, carry_we, zero_we);
endinterface

// >>> core/iso_alu.sv
`timescale 1ns/100ps
module iso_alu (
   iso_alu_if.alu a
);
   // result and flag effects per operation
   always_comb begin
      a.result = a.src;
      a.carry_out = a.carry_in;
      a.carry_we = 1'b0;
      a.zero_we = 1'b0;
      case (a.op)
         iso_pkg::ISO_OP_INC: begin
            a.result = a.src + iso_pkg::ISO_ONE;
            a.zero_we = 1'b1;
         end
         iso_pkg::ISO_OP_IOR: begin
            a.result = a.acc | a.src;
            a.zero_we = 1'b1;
         end
         iso_pkg::ISO_OP_LSL: begin
            a.result = {a.src[6:0], 1'b0};
            a.carry_out = a.src[iso_pkg::ISO_MSB];
            a.carry_we = 1'b1;
            a.zero_we = 1'b1;
         end
         iso_pkg::ISO_OP_LSR: begin
            a.result = {1'b0, a.src[7:1]};
            a.carry_out = a.src[iso_pkg::ISO_LSB];
            a.carry_we = 1'b1;
            a.zero_we = 1'b1;
         end
         iso_pkg::ISO_OP_MOV: begin
            a.result = a.src;
            a.zero_we = 1'b1;
         end
         default: begin
            a.result = a.src;
         end
      endcase
   end

   // zero flag from the full 8-bit result
   assign a.zero_out = (a.result == iso_pkg::ISO_ZERO);
endmodule // iso_alu

// >>> core/iso_core.sv
`timescale 1ns/100ps
// Overview of operation
// - destination bit 0 writes accumulator, 1 writes addressed register
// - register address is 7 bits, 0 to 127; destination 0 or 1
// - increment adds one, updates zero only, carry kept
// - inclusive or of accumulator and register, updates zero only
// - left shift moves bits up, bit 7 to carry, updates carry, zero
// - left shift always puts zero in result bit 0
// - right shift moves bits down, bit 0 to carry, msb zero
// - move copies register unchanged, updates zero for testing
module iso_core (
   input wire logic clk_sys,
   input wire logic rst,
   input wire iso_pkg::iso_op_t op,
   input wire logic [6:0] addr,
   input wire logic dest,
   output logic [7:0] acc,
   output logic carry,
   output logic zero,
   output logic [7:0] file_rdata
);
   typedef struct packed {
      logic [7:0] acc;
      logic carry;
      logic zero;
   } iso_state_t;

   iso_state_t s_q;
   iso_state_t s_d;
   logic [7:0] file_q [iso_pkg::ISO_DEPTH];
   logic file_we;
   logic op_valid;
   logic [7:0] rd_q;
   iso_alu_if alu_bus ();

   iso_alu u_alu (
      .a(alu_bus.alu)
   );

   // operands to the alu
   assign alu_bus.op = op;
   assign alu_bus.acc = s_q.acc;
   assign alu_bus.src = file_q[addr];
   assign alu_bus.carry_in = s_q.carry;

   // only the five defined codes may write; idle and spare codes are ignored
   assign op_valid = op inside {iso_pkg::ISO_OP_INC, iso_pkg::ISO_OP_IOR,
      iso_pkg::ISO_OP_LSL, iso_pkg::ISO_OP_LSR, iso_pkg::ISO_OP_MOV};

   // file write only for a real op aimed at the register
   assign file_we = op_valid &&
      (dest == iso_pkg::ISO_DEST_REG);

   // next state of accumulator and flags
   always_comb begin
      s_d = s_q;
      if (op_valid &&
         dest == iso_pkg::ISO_DEST_ACC) begin
         s_d.acc = alu_bus.result;
      end
      if (alu_bus.carry_we) begin
         s_d.carry = alu_bus.carry_out;
      end
      if (alu_bus.zero_we) begin
         s_d.zero = alu_bus.zero_out;
      end
   end

   // state registered each cycle, one op per cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '{acc: iso_pkg::ISO_ACC_RST, carry: 1'b0, zero: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // data register file, written back in the same cycle
   generate
      for (genvar i = 0; i < iso_pkg::ISO_DEPTH; i++) begin : g_file
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               file_q[i] <= iso_pkg::ISO_FILE_RST;
            end else if (file_we && addr == 7'(i)) begin
               file_q[i] <= alu_bus.result;
            end
         end
      end
   endgenerate

   // registered read port shows the addressed register after the edge
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_q <= iso_pkg::ISO_FILE_RST;
      end else if (file_we) begin
         rd_q <= alu_bus.result;
      end else begin
         rd_q <= file_q[addr];
      end
   end

   assign acc = s_q.acc;
   assign carry = s_q.carry;
   assign zero = s_q.zero;
   assign file_rdata = rd_q;
endmodule // iso_core

// >>> verification/iso_monitor.sv
`timescale 1ns/100ps
module iso_monitor (
   input logic clk_sys,
   input logic rst,
   input iso_pkg::iso_op_t op,
   input logic dest,
   input logic [7:0] acc,
   input logic carry,
   input logic zero,
   input logic [7:0] file_rdata
);
   logic act;
   // any writing op
   assign act = op inside {[3'h1:3'h5]};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_carry_kept: assert property (!(op inside {3'h3, 3'h4})
      |=> $stable(carry)) else $error("carry moved");
   a_acc_kept: assert property (act && dest |=> $stable(acc))
      else $error("acc moved");
   a_idle_hold: assert property (!act |=> $stable({acc, zero}))
      else $error("idle op");
   a_zero_acc: assert property (act && !dest |=> zero == !acc)
      else $error("zero acc");
   a_zero_reg: assert property (
      act && dest |=> zero == !file_rdata) else $error("zero reg");
   a_or_bits: assert property (op == 3'h2 && !dest
      |=> &(acc | ~$past(acc))) else $error("or bits");
   a_lsl_lsb: assert property (op == 3'h3 && !dest |=> !acc[0])
      else $error("lsl lsb");
   a_lsr_msb: assert property (op == 3'h4 && !dest |=> !acc[7])
      else $error("lsr msb");
endmodule // iso_monitor
bind iso_core iso_monitor i_mon (.clk_sys, .rst, .op, .dest, .acc, .carry,
   .zero, .file_rdata);

// >>> verification/increment_or_shift_move_ops_test.sv
`timescale 1ns/100ps
module increment_or_shift_move_ops_test;
   logic clk_sys = 1'h0, rst = 1'h1, cm = 1'h0, zm = 1'h0, carry, zero;
   logic [7:0] acc, file_rdata, r = 8'h5c, am = 8'h00;
   logic [7:0] mem [128] = '{default: 8'h00};
   logic [6:0] addr = 7'h00;
   logic dest = 1'h0;
   int miscompares = 0, cmp_count = 0;
   iso_pkg::iso_op_t op = iso_pkg::ISO_OP_NONE;
   iso_core i_dut (.clk_sys, .rst, .op, .addr, .dest, .acc, .carry, .zero,
      .file_rdata);
   function automatic logic [7:0] lfsr(logic [7:0] v);
      return {v[6:0], ^(v & 8'hb8)};
   endfunction
   // reference model
   function automatic void model(logic [7:0] s);
      logic [8:0] e;
      case (op)
         3'h1: e = {cm, s + 8'h01};
         3'h2: e = {cm, s | am};
         3'h3: e = {s, 1'h0};
         3'h4: e = {s[0], 1'h0, s[7:1]};
         3'h5: e = {cm, s};
         default: return;
      endcase
      {cm, zm} = {e[8], !e[7:0]};
      if (dest) mem[addr] = e[7:0];
      else am = e[7:0];
   endfunction
   task automatic check(logic [17:0] g, x);
      cmp_count++;
      miscompares += int'(g !== x);
      if (g !== x) $display("wrong value at %0t: %h", $time, g);
   endtask
   // one op: drive just after an edge, model and compare after the next
   task automatic step(iso_pkg::iso_op_t o, logic [6:0] a, logic d);
      op = o;
      addr = a;
      dest = d;
      @(posedge clk_sys);
      model(mem[addr]);
      #1 check({carry, zero, acc, file_rdata},
         {cm, zm, am, mem[addr]});
   endtask
   task automatic summarize;
      $display("%0d wrong of %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // clock, watchdog
   initial forever #4 clk_sys = ~clk_sys;
   initial begin
      #20000 miscompares++;
      summarize;
   end
   // stimulus: corner cases, code sweep, then random ops
   initial begin
      repeat (3) @(posedge clk_sys);
      #1 rst = 1'h0;
      // walk a one up to bit 7 and out into carry, mid address
      step(iso_pkg::ISO_OP_INC, 7'h40, 1'h1);
      repeat (7) step(iso_pkg::ISO_OP_LSL, 7'h40, 1'h1);
      step(iso_pkg::ISO_OP_LSL, 7'h40, 1'h0);
      step(iso_pkg::ISO_OP_INC, 7'h40, 1'h0);
      step(iso_pkg::ISO_OP_LSR, 7'h40, 1'h0);
      // build all ones at the top address, then wrap it to zero
      repeat (8) begin
         step(iso_pkg::ISO_OP_LSL, 7'h7f, 1'h1);
         step(iso_pkg::ISO_OP_INC, 7'h7f, 1'h1);
      end
      step(iso_pkg::ISO_OP_LSR, 7'h7f, 1'h0);
      step(iso_pkg::ISO_OP_INC, 7'h7f, 1'h1);
      step(iso_pkg::ISO_OP_MOV, 7'h7f, 1'h1);
      step(iso_pkg::ISO_OP_IOR, 7'h7f, 1'h1);
      step(iso_pkg::iso_op_t'(3'h7), 7'h7f, 1'h0);
      for (int n = 0; n < 900; n++) begin
         step(iso_pkg::iso_op_t'(n < 8 ? n[2:0] : r[2:0]),
            {{4{r[7]}}, r[5:3]}, r[6]);
         r = lfsr(r);
      end
      summarize;
   end
endmodule // increment_or_shift_move_ops_test
